// ==== common/tamper_pkg.sv ====
// Purpose: constants for the tamper detect and RAM clear block
// Assumes: 250 MHz core clock; times given in their own units
// Notes:   long counts are derived here and overridable at the top
package tamper_pkg;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned NUM_CH       = 2;
  localparam int unsigned RAM_DEPTH    = 128;
  localparam int unsigned RAM_AW       = 7;
  localparam int unsigned RAM_DW       = 8;
  localparam logic [7:0]  FLAGS_ADDR   = 8'h0f;
  localparam logic [7:0]  CLOCK_FIRST  = 8'h00;
  localparam logic [7:0]  CLOCK_LAST   = 8'h07;
  // Times in microseconds and seconds as printed
  localparam int unsigned DELAY_TYP_US    = 1500;
  localparam int unsigned DELAY_OF_US     = 500;
  localparam int unsigned SAMPLE_PERIOD_S = 1;
  localparam int unsigned SAMPLE_WIN_US   = 1000;
  localparam int unsigned WIDTH_S0 = 1;
  localparam int unsigned WIDTH_S1 = 4;
  localparam int unsigned WIDTH_S2 = 8;
  localparam int unsigned WIDTH_S3 = 16;
  localparam int unsigned RECOVERY_US = 200;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned DELAY_TYP_CYC = DELAY_TYP_US * CYC_PER_US;
  localparam int unsigned DELAY_OF_CYC  = DELAY_OF_US * CYC_PER_US;
  localparam int unsigned SAMPLE_WIN_CYC = SAMPLE_WIN_US * CYC_PER_US;
  localparam int unsigned RECOVERY_CYC  = RECOVERY_US * CYC_PER_US;
  localparam int unsigned CNT_W = 40;
  localparam logic [1:0] WIDTH_1S  = 2'h0;
  localparam logic [1:0] WIDTH_4S  = 2'h1;
  localparam logic [1:0] WIDTH_8S  = 2'h2;
  localparam logic [1:0] WIDTH_16S = 2'h3;
endpackage

// ==== core/tamper_channel.sv ====
// Purpose: one tamper detection channel
// Assumes: pin already synchronised; sample tick from the top
// Notes:   flag holds until enable goes low
`timescale 1ns/1ps
`default_nettype none
module tamper_channel
  import tamper_pkg::*;
(
  input  wire logic clk_in,          // Core clock
  input  wire logic reset_in,        // Sync reset
  input  wire logic pin_in,          // Synchronised tamper input
  input  wire logic enable_in,       // Channel enable
  input  wire logic normally_open_in,// Switch mode
  input  wire logic polarity_in,     // 1 = high triggers
  input  wire logic sampling_in,     // 1 = 1Hz sampling
  input  wire logic pull_strong_in,  // Pull strength select
  input  wire logic osc_running_in,  // Oscillator running
  input  wire logic window_in,       // Sampling window open
  output logic      flag_out,        // Tamper flag
  output logic      event_out,       // One-cycle tamper event
  output logic      pull_on_out,     // Internal pull enabled
  output logic      pull_strong_out  // Strong pull applied
);
  logic flag_q;
  logic active;
  logic look;

  assign active = (pin_in == polarity_in);
  // Sampling only in normally-closed mode with running oscillator
  assign look = normally_open_in || !sampling_in || !osc_running_in
                || window_in;

  always_ff @(posedge clk_in) begin
    if (reset_in || !enable_in) begin
      flag_q <= 1'b0;
    end else if (active && look) begin
      flag_q <= 1'b1;
    end
  end

  assign event_out = enable_in && !flag_q && active && look;
  assign flag_out  = flag_q;
  assign pull_on_out = enable_in && !normally_open_in && look && !flag_q;
  assign pull_strong_out = !normally_open_in && pull_strong_in;
endmodule
`default_nettype wire

// ==== core/tamper_top.sv ====
// Purpose: two-channel tamper detect with RAM and external clear
// Assumes: one 250 MHz clock, control bits as plain ports
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module tamper_top
  import tamper_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_S * CLK_HZ,
  parameter int unsigned SAMPLE_WIN_P      = SAMPLE_WIN_CYC,
  parameter int unsigned DELAY_CYC_P       = DELAY_TYP_CYC,
  parameter int unsigned DELAY_OF_CYC_P    = DELAY_OF_CYC,
  parameter int unsigned RECOVERY_CYC_P    = RECOVERY_CYC,
  parameter longint unsigned SECOND_CYC_P  = longint'(CLK_HZ)
)(
  input  wire logic              clk_in,                  // Core clock
  input  wire logic              reset_in,                // Sync reset
  input  wire logic              tamper_input_1_in,       // Tamper pin 1, async
  input  wire logic              tamper_input_2_in,       // Tamper pin 2, async
  input  wire logic [1:0]        tamper_channel_enable_in,// Per-channel enable
  input  wire logic [1:0]        switch_normally_open_select_in, // 1 = normally open
  input  wire logic [1:0]        trigger_polarity_select_in, // 1 = high triggers
  input  wire logic [1:0]        sampling_select_in,      // 1 = 1Hz sampling
  input  wire logic [1:0]        pull_strength_select_in, // 1 = strong pull
  input  wire logic [1:0]        tamper_interrupt_enable_in, // Interrupt enables
  input  wire logic              internal_ram_clear_ch1_in, // RAM clear ch1
  input  wire logic              internal_ram_clear_ch2_in, // RAM clear ch2
  input  wire logic              external_clear_ch1_in,   // Ext clear ch1
  input  wire logic              external_clear_ch2_in,   // Ext clear ch2
  input  wire logic              clear_width_bit0_in,     // Width field bit 0
  input  wire logic              clear_width_bit1_in,     // Width field bit 1
  input  wire logic              oscillator_fail_flag_in, // Oscillator fail
  input  wire logic              osc_running_in,          // Oscillator running, async
  input  wire logic              on_battery_in,           // Running from battery, async
  input  wire logic              other_reset_req_in,      // Other reset sources
  input  wire logic              flags_read_in,           // Flags register read strobe
  input  wire logic              ram_wr_in,               // User RAM write
  input  wire logic [RAM_AW-1:0] ram_addr_in,             // User RAM address
  input  wire logic [RAM_DW-1:0] ram_wdata_in,            // User RAM write data
  output logic      [RAM_DW-1:0] ram_rdata_out,           // User RAM read data
  output logic                   ram_blocked_out,         // RAM access blocked
  output logic      [1:0]        tamper_flag_out,         // Tamper flags
  output logic      [7:0]        flags_reg_out,           // Flags register image
  output logic                   irq_n_out,               // Interrupt pin, low active
  output logic                   external_clear_strobe_out, // Ext clear, high active
  output logic                   reset_n_out,             // Supervisor reset, low active
  output logic                   supply_battery_disc_out, // Supply off battery
  output logic                   supply_ground_out,       // Supply forced to ground
  output logic                   clock_freeze_out,        // Freeze clock regs
  output logic      [1:0]        pull_on_out,             // Internal pull enables
  output logic      [1:0]        pull_strong_out          // Strong pull selects
);
  typedef enum logic [3:0] {
    CLR_IDLE  = 4'h1,
    CLR_DELAY = 4'h2,
    CLR_PULSE = 4'h4,
    CLR_DONE  = 4'h8
  } clr_state_e;

  function automatic longint unsigned width_cycles(input logic [1:0] sel);
    case (sel)
      WIDTH_1S:  width_cycles = longint'(WIDTH_S0) * SECOND_CYC_P;
      WIDTH_4S:  width_cycles = longint'(WIDTH_S1) * SECOND_CYC_P;
      WIDTH_8S:  width_cycles = longint'(WIDTH_S2) * SECOND_CYC_P;
      default:   width_cycles = longint'(WIDTH_S3) * SECOND_CYC_P;
    endcase
  endfunction

  // Two-flop synchronisers for all asynchronous levels
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {on_battery_in, osc_running_in, tamper_input_2_in, tamper_input_1_in};
      sync2_q <= sync1_q;
    end
  end
  logic [1:0] pin_s;
  logic       osc_s;
  logic       batt_s;
  assign pin_s  = sync2_q[1:0];
  assign osc_s  = sync2_q[2];
  assign batt_s = sync2_q[3];

  // Sampling tick: 1 s period, window about 1 ms
  logic [CNT_W-1:0] samp_cnt_q;
  logic             window;
  always_ff @(posedge clk_in) begin
    if (reset_in || !osc_s) begin
      samp_cnt_q <= '0;
    end else if (samp_cnt_q >= CNT_W'(SAMPLE_PERIOD_CYC - 1)) begin
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + 1'b1;
    end
  end
  assign window = samp_cnt_q < CNT_W'(SAMPLE_WIN_P);

  // Two independent channels
  logic [1:0] flag;
  logic [1:0] evt;
  genvar g;
  for (g = 0; g < NUM_CH; g++) begin : gen_ch
    tamper_channel u_ch (
      .clk_in           (clk_in),
      .reset_in         (reset_in),
      .pin_in           (pin_s[g]),
      .enable_in        (tamper_channel_enable_in[g]),
      .normally_open_in (switch_normally_open_select_in[g]),
      .polarity_in      (trigger_polarity_select_in[g]),
      .sampling_in      (sampling_select_in[g]),
      .pull_strong_in   (pull_strength_select_in[g]),
      .osc_running_in   (osc_s),
      .window_in        (window),
      .flag_out         (flag[g]),
      .event_out        (evt[g]),
      .pull_on_out      (pull_on_out[g]),
      .pull_strong_out  (pull_strong_out[g])
    );
  end
  // Battery state does not gate detection
  assign tamper_flag_out = flag;
  assign flags_reg_out   = {6'h00, flag};

  // Either clear bit applies to whichever enabled channel trips
  logic ram_clr_en;
  logic ext_clr_en;
  logic any_evt;
  assign ram_clr_en = internal_ram_clear_ch1_in || internal_ram_clear_ch2_in;
  assign ext_clr_en = external_clear_ch1_in || external_clear_ch2_in;
  assign any_evt    = |evt;

  // Block held per channel until that channel's enable drops
  logic [1:0] block_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      block_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (evt[i] && ram_clr_en) begin
          block_q[i] <= 1'b1;
        end else if (!tamper_channel_enable_in[i]) begin
          block_q[i] <= 1'b0;
        end
      end
    end
  end
  assign ram_blocked_out = |block_q;

  user_ram u_ram (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clear_in  (any_evt && ram_clr_en),
    .block_in  (ram_blocked_out),
    .wr_in     (ram_wr_in),
    .addr_in   (ram_addr_in),
    .wdata_in  (ram_wdata_in),
    .rdata_out (ram_rdata_out),
    .busy_out  ()
  );

  // Time-stamp freeze holds while any flag stands
  logic freeze_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      freeze_q <= 1'b0;
    end else begin
      freeze_q <= any_evt || (|flag);
    end
  end
  assign clock_freeze_out = freeze_q || any_evt;

  // External clear sequencer
  clr_state_e       clr_q;
  logic [CNT_W-1:0] clr_cnt_q;
  logic [CNT_W-1:0] delay_cyc;
  logic [1:0]       width_sel;
  assign width_sel = {clear_width_bit1_in, clear_width_bit0_in};
  // Oscillator fail shortens the start delay
  assign delay_cyc = oscillator_fail_flag_in ? CNT_W'(DELAY_OF_CYC_P)
                                             : CNT_W'(DELAY_CYC_P);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      clr_q     <= CLR_IDLE;
      clr_cnt_q <= '0;
    end else begin
      case (clr_q)
        CLR_IDLE: begin
          clr_cnt_q <= '0;
          if (any_evt && ext_clr_en) begin
            clr_q <= CLR_DELAY;
          end
        end
        CLR_DELAY: begin
          clr_cnt_q <= clr_cnt_q + 1'b1;
          if (clr_cnt_q >= delay_cyc - 1'b1) begin
            clr_cnt_q <= '0;
            clr_q     <= CLR_PULSE;
          end
        end
        CLR_PULSE: begin
          clr_cnt_q <= clr_cnt_q + 1'b1;
          if (clr_cnt_q >= CNT_W'(width_cycles(width_sel) - 1)) begin
            clr_q <= CLR_DONE;
          end
        end
        CLR_DONE: begin
          // Re-arm only once no flag stands
          clr_cnt_q <= '0;
          if (flag == 2'b00) begin
            clr_q <= CLR_IDLE;
          end
        end
        default: clr_q <= CLR_IDLE;
      endcase
    end
  end

  logic strobe_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= (clr_q == CLR_PULSE);
    end
  end
  assign external_clear_strobe_out = strobe_q;

  // Supply handling follows the power source at the moment of clear
  logic disc_q;
  logic gnd_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      disc_q <= 1'b0;
      gnd_q  <= 1'b0;
    end else begin
      disc_q <= (clr_q == CLR_PULSE) && batt_s;
      gnd_q  <= (clr_q == CLR_PULSE) && !batt_s;
    end
  end
  assign supply_battery_disc_out = disc_q;
  assign supply_ground_out       = gnd_q;

  // Shared reset stretcher, same for every source
  logic [CNT_W-1:0] rst_cnt_q;
  logic             rst_act_q;
  logic             rst_req;
  assign rst_req = other_reset_req_in || (clr_q == CLR_DELAY && clr_cnt_q == '0);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_cnt_q <= '0;
      rst_act_q <= 1'b0;
    end else if (rst_req) begin
      rst_cnt_q <= CNT_W'(RECOVERY_CYC_P);
      rst_act_q <= 1'b1;
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
      rst_act_q <= (rst_cnt_q != CNT_W'(1));
    end else begin
      rst_act_q <= 1'b0;
    end
  end
  assign reset_n_out = !rst_act_q;

  // Interrupt pin: set wins over every release
  logic       irq_q;
  logic       irq_set;
  logic [1:0] tie_q;
  logic       tie_fall;
  assign irq_set  = |(evt & tamper_interrupt_enable_in);
  // Any enable bit written to zero releases the shared pin
  assign tie_fall = |(tie_q & ~tamper_interrupt_enable_in);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tie_q <= '0;
    end else begin
      tie_q <= tamper_interrupt_enable_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (flags_read_in || rst_act_q || tie_fall) begin
      irq_q <= 1'b0;
    end
  end
  assign irq_n_out = !irq_q;
endmodule
`default_nettype wire

// ==== core/user_ram.sv ====
// Purpose: 128-byte user RAM with bulk clear and access block
// Assumes: single clock, one access per cycle
// Notes:   clear walks one address per cycle
`timescale 1ns/1ps
`default_nettype none
module user_ram
  import tamper_pkg::*;
(
  input  wire logic              clk_in,      // Core clock
  input  wire logic              reset_in,    // Sync reset
  input  wire logic              clear_in,    // Start bulk clear
  input  wire logic              block_in,    // Access blocked
  input  wire logic              wr_in,       // Write strobe
  input  wire logic [RAM_AW-1:0] addr_in,     // Byte address
  input  wire logic [RAM_DW-1:0] wdata_in,    // Write data
  output logic      [RAM_DW-1:0] rdata_out,   // Read data, registered
  output logic                   busy_out     // Clear in progress
);
  logic [RAM_DW-1:0] mem_q [RAM_DEPTH];
  logic [RAM_AW-1:0] clr_addr_q;
  logic              busy_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy_q     <= 1'b0;
      clr_addr_q <= '0;
    end else if (clear_in && !busy_q) begin
      busy_q     <= 1'b1;
      clr_addr_q <= '0;
    end else if (busy_q) begin
      clr_addr_q <= clr_addr_q + 1'b1;
      if (clr_addr_q == RAM_AW'(RAM_DEPTH - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (busy_q) begin
      mem_q[clr_addr_q] <= '0;
    end else if (wr_in && !block_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  // Blocked reads return zero, never the cleared contents
  always_ff @(posedge clk_in) begin
    if (reset_in || block_in || busy_q) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[addr_in];
    end
  end

  assign busy_out = busy_q;
endmodule
`default_nettype wire

// ==== verification/tamper_monitor.sv ====
// Purpose: port-level checks of the tamper block
// Assumes: recovery count handed on by the bind
// Notes:   recovery length measured by a helper counter
`timescale 1ns/1ps
`default_nettype none
module tamper_monitor
  import tamper_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC_P = 30
)(
  input wire logic              clk_in,                         // Clock
  input wire logic              reset_in,                       // Reset
  input wire logic [1:0]        tamper_channel_enable_in,       // Enables
  input wire logic [1:0]        switch_normally_open_select_in, // Mode
  input wire logic [1:0]        tamper_interrupt_enable_in,     // Irq enables
  input wire logic              external_clear_ch1_in,          // Ext clear
  input wire logic              flags_read_in,                  // Flags read
  input wire logic [RAM_DW-1:0] ram_rdata_out,                  // RAM data
  input wire logic              ram_blocked_out,                // Blocked
  input wire logic [1:0]        tamper_flag_out,                // Flags
  input wire logic [7:0]        flags_reg_out,                  // Flags image
  input wire logic              irq_n_out,                      // Irq
  input wire logic              external_clear_strobe_out,      // Strobe
  input wire logic              reset_n_out,                    // Reset out
  input wire logic              supply_battery_disc_out,        // Supply
  input wire logic              supply_ground_out,              // Supply
  input wire logic              clock_freeze_out,               // Freeze
  input wire logic [1:0]        pull_strong_out                 // Pull
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] low_cnt_q;
  always_ff @(posedge clk_in) begin
    low_cnt_q <= (reset_in || reset_n_out) ? 16'h0000 : low_cnt_q + 16'h0001;
  end
  AST_FLAG_EN: assert property ($rose(tamper_flag_out[0]) |-> $past(tamper_channel_enable_in[0]))
    else $error("flag set while channel disabled");
  AST_FLAG_HOLD: assert property (tamper_flag_out[0] && tamper_channel_enable_in[0] |=> tamper_flag_out[0])
    else $error("flag dropped while enabled");
  AST_FLAG_CLEAR: assert property (!tamper_channel_enable_in[1] |=> !tamper_flag_out[1])
    else $error("flag kept after enable low");
  AST_IRQ_SET: assert property ($rose(tamper_flag_out[0]) && tamper_interrupt_enable_in[0] |-> !irq_n_out)
    else $error("irq not driven on tamper");
  AST_IRQ_REL: assert property (flags_read_in ##1 !$rose(tamper_flag_out[0]) && !$rose(tamper_flag_out[1]) |-> irq_n_out)
    else $error("irq kept after flags read");
  AST_EXT_RESET: assert property ($rose(tamper_flag_out[0]) && external_clear_ch1_in && !$past(tamper_flag_out[1]) |-> ##[0:3] !reset_n_out)
    else $error("no reset after external clear tamper");
  AST_RECOVERY: assert property ($rose(reset_n_out) |-> 32'(low_cnt_q) >= RECOVERY_CYC_P && 32'(low_cnt_q) <= RECOVERY_CYC_P + 1)
    else $error("reset length wrong");
  AST_SUPPLY: assert property (external_clear_strobe_out |-> ##[0:1] (supply_battery_disc_out || supply_ground_out))
    else $error("supply not cut during strobe");
  AST_RAM_READ: assert property (ram_blocked_out |=> ram_rdata_out == 8'h00)
    else $error("blocked RAM returned data");
  AST_FREEZE: assert property ((|tamper_flag_out) |-> clock_freeze_out)
    else $error("clock not frozen");
  AST_FLAGS_REG: assert property (flags_reg_out == {6'h00, tamper_flag_out})
    else $error("flags image wrong");
  AST_PULL: assert property (switch_normally_open_select_in[0] |-> !pull_strong_out[0])
    else $error("pull select used in open mode");
  cover property ($rose(external_clear_strobe_out));
  cover property ($fell(reset_n_out));
  cover property ($rose(tamper_flag_out[1]));
endmodule
bind tamper_top tamper_monitor #(.RECOVERY_CYC_P(RECOVERY_CYC_P)) mon (
  .clk_in(clk_in), .reset_in(reset_in), .tamper_channel_enable_in(tamper_channel_enable_in),
  .switch_normally_open_select_in(switch_normally_open_select_in),
  .tamper_interrupt_enable_in(tamper_interrupt_enable_in),
  .external_clear_ch1_in(external_clear_ch1_in), .flags_read_in(flags_read_in),
  .ram_rdata_out(ram_rdata_out), .ram_blocked_out(ram_blocked_out),
  .tamper_flag_out(tamper_flag_out), .flags_reg_out(flags_reg_out), .irq_n_out(irq_n_out),
  .external_clear_strobe_out(external_clear_strobe_out), .reset_n_out(reset_n_out),
  .supply_battery_disc_out(supply_battery_disc_out), .supply_ground_out(supply_ground_out),
  .clock_freeze_out(clock_freeze_out), .pull_strong_out(pull_strong_out));
`default_nettype wire

// ==== verification/tamper_switch_model.sv ====
// Purpose: external switch and pull model for both tamper pins
// Assumes: a released pin with no pull rests at its idle level
// Notes:   idle level is the inverse of the trigger level
`timescale 1ns/1ps
`default_nettype none
module tamper_switch_model (
  input  wire logic [1:0] actuate_in,  // Switch in tamper position
  input  wire logic [1:0] nopen_in,    // 1 = normally open
  input  wire logic [1:0] polarity_in, // Trigger level
  input  wire logic [1:0] pull_on_in,  // Internal pull active
  output logic      [1:0] pin_out      // Pin levels
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Open contact closes to the rail, closed contact lets the pull win
      pin_out[i] = (actuate_in[i] && (nopen_in[i] || pull_on_in[i])) ? polarity_in[i]
                                                                      : !polarity_in[i];
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_tamper_top.sv ====
// Purpose: self-checking bench for the two-channel tamper block
// Assumes: shortened counts; switch model drives the pins
// Notes:   all four strobe widths run, the last with oscillator fail
`timescale 1ns/1ps
`default_nettype none
module tb_tamper_top
  import tamper_pkg::*;
;
  localparam int SEC = 50;
  localparam int DLY = 20;
  localparam int DLY_OF = 5;
  localparam int LIM = 2000;
  localparam int SPER = 1000;
  localparam int SWIN = 10;
  localparam int REC = 30;
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic [1:0] act, en, nopen, pol, samp, pull, tamper_interrupt_enable, pins, flag, pull_on, pull_strong;
  logic       ram_clr, ext_clr, w0, w1, of_flag, osc_run, on_bat, frd, wr, orq;
  logic       blocked, irq_n, strobe, rst_n, sbat, sgnd, freeze;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, flags_reg;
  int         bad_count, check_count;
  always #2 clk_in = ~clk_in;
  tamper_switch_model sw (.actuate_in(act), .nopen_in(nopen), .polarity_in(pol),
    .pull_on_in(pull_on), .pin_out(pins));
  tamper_top #(.SAMPLE_PERIOD_CYC(SPER), .SAMPLE_WIN_P(SWIN), .DELAY_CYC_P(DLY),
    .DELAY_OF_CYC_P(DLY_OF), .RECOVERY_CYC_P(REC), .SECOND_CYC_P(SEC)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .tamper_input_1_in(pins[0]),
    .tamper_input_2_in(pins[1]), .tamper_channel_enable_in(en),
    .switch_normally_open_select_in(nopen), .trigger_polarity_select_in(pol),
    .sampling_select_in(samp), .pull_strength_select_in(pull),
    .tamper_interrupt_enable_in(tamper_interrupt_enable), .internal_ram_clear_ch1_in(ram_clr),
    .internal_ram_clear_ch2_in(1'b0), .external_clear_ch1_in(ext_clr),
    .external_clear_ch2_in(1'b0), .clear_width_bit0_in(w0), .clear_width_bit1_in(w1),
    .oscillator_fail_flag_in(of_flag), .osc_running_in(osc_run), .on_battery_in(on_bat),
    .other_reset_req_in(orq), .flags_read_in(frd), .ram_wr_in(wr), .ram_addr_in(addr),
    .ram_wdata_in(wdata), .ram_rdata_out(rdata), .ram_blocked_out(blocked),
    .tamper_flag_out(flag), .flags_reg_out(flags_reg), .irq_n_out(irq_n),
    .external_clear_strobe_out(strobe), .reset_n_out(rst_n),
    .supply_battery_disc_out(sbat), .supply_ground_out(sgnd), .clock_freeze_out(freeze),
    .pull_on_out(pull_on), .pull_strong_out(pull_strong));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? flag[0] : (s == 1) ? flag[1] : (s == 2) ? strobe : irq_n;
  endfunction
  // Bounded wait; running out ends the run as a mismatch
  task automatic await(input int s, input logic v, output int n);
    for (n = 0; n < LIM && sig(s) !== v; n++) cyc(1);
    if (n >= LIM) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic ext_run(input logic [1:0] w);
    int n;
    int wd;
    int d;
    wd = (w == 2'h0) ? 1 : (w == 2'h1) ? 4 : (w == 2'h2) ? 8 : 16;
    d = (w == 2'h3) ? DLY_OF : DLY;
    @(posedge clk_in);
    {w1, w0} <= w;
    of_flag <= (w == 2'h3);
    on_bat <= w[0];
    en[0] <= 1'b1;
    wr <= 1'b1;
    @(posedge clk_in) wr <= 1'b0;
    cyc(5);
    check("ram before", rdata, 8'ha5);
    @(posedge clk_in) act[0] <= 1'b1;
    await(0, 1'b1, n);
    check("flag latency", n <= 4, 1'b1);
    check("irq", irq_n, 1'b0);
    check("freeze", freeze, 1'b1);
    check("flags reg", flags_reg, 8'h01);
    await(2, 1'b1, n);
    check("clear delay", n >= d && n <= d + 3, 1'b1);
    check("reset out", rst_n, 1'b0);
    check("irq by reset", irq_n, 1'b1);
    check("blocked", blocked, 1'b1);
    cyc(2);
    check("off battery", sbat, w[0]);
    check("to ground", sgnd, !w[0]);
    await(2, 1'b0, n);
    check("strobe width", n + 2 >= wd * SEC - 1 && n + 2 <= wd * SEC + 1, 1'b1);
    // Service order: read flags, drop enable, re-arm on the next run
    @(posedge clk_in) act[0] <= 1'b0;
    frd <= 1'b1;
    @(posedge clk_in) frd <= 1'b0;
    @(posedge clk_in) en[0] <= 1'b0;
    // Bulk clear must finish before the next run writes again
    cyc(RAM_DEPTH);
    check("flag cleared", flag[0], 1'b0);
    check("unblocked", blocked, 1'b0);
    check("ram zeroed", rdata, 8'h00);
  endtask
  task automatic irq_run();
    int n;
    @(posedge clk_in);
    {ram_clr, ext_clr, osc_run} <= 3'h0;
    {nopen[1], pol[1], samp[1]} <= 3'h3;
    en[0] <= 1'b1;
    cyc(5);
    check("pull ignored", pull_strong[0], 1'b0);
    check("pull used", pull_strong[1], 1'b1);
    @(posedge clk_in) act[1] <= 1'b1;
    cyc(10);
    check("disabled", flag[1], 1'b0);
    // Restarted oscillator opens a window; enable after it shuts
    @(posedge clk_in) osc_run <= 1'b1;
    cyc(2 * SWIN);
    @(posedge clk_in) en[1] <= 1'b1;
    await(1, 1'b1, n);
    check("sampled", n > SWIN && n <= SPER + 5, 1'b1);
    @(posedge clk_in) en[1] <= 1'b0;
    osc_run <= 1'b0;
    cyc(5);
    @(posedge clk_in) en[1] <= 1'b1;
    await(1, 1'b1, n);
    check("osc stopped", n <= 5, 1'b1);
    check("ch1 quiet", flag[0], 1'b0);
    check("irq ch2", irq_n, 1'b0);
    check("no strobe", strobe, 1'b0);
    check("no reset", rst_n, 1'b1);
    @(posedge clk_in) frd <= 1'b1;
    @(posedge clk_in) frd <= 1'b0;
    cyc(1);
    check("read release", irq_n, 1'b1);
    check("flag held", flag[1], 1'b1);
    @(posedge clk_in) en[1] <= 1'b0;
    @(posedge clk_in) en[1] <= 1'b1;
    await(3, 1'b0, n);
    @(posedge clk_in) tamper_interrupt_enable[1] <= 1'b0;
    cyc(2);
    check("enable release", irq_n, 1'b1);
    @(posedge clk_in) orq <= 1'b1;
    @(posedge clk_in) orq <= 1'b0;
    cyc(2);
    check("other reset", rst_n, 1'b0);
    cyc(REC);
    check("other reset end", rst_n, 1'b1);
  endtask
  initial begin
    bad_count = 0;
    check_count = 0;
    {act, en, pol, samp} = 8'h00;
    {nopen, pull, tamper_interrupt_enable} = 6'h3f;
    {orq, frd, wr, of_flag, on_bat, w0, w1} = 7'h00;
    {ram_clr, ext_clr, osc_run} = 3'h7;
    addr = 7'h09;
    wdata = 8'ha5;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    cyc(5);
    check("strobe idle", strobe, 1'b0);
    check("irq idle", irq_n, 1'b1);
    check("flags idle", flag, 2'h0);
    for (int i = 0; i < 4; i++) ext_run(2'(i));
    irq_run();
    finish_test();
  end
endmodule
`default_nettype wire
